/* File: hw/hdlw_consts.vh */
// Constants for the handheld display line writer
`ifndef HDLW_CONSTS_VH
`define HDLW_CONSTS_VH

`define HDLW_OFS_MODE        5'h00
`define HDLW_OFS_CTRL        5'h01
`define HDLW_OFS_CHAR_FIRST  5'h04
`define HDLW_OFS_CHAR_LAST   5'h13
`define HDLW_IN_OFS_ACK      5'h05
`define HDLW_BIT_REQ         7
`define HDLW_BIT_ACK         7
`define HDLW_BIT_MODE        7
`define HDLW_SEL_LSB         0
`define HDLW_SEL_MSB         1
`define HDLW_NUM_LINES       4
`define HDLW_NUM_CHARS       16
`define HDLW_CHAR_SPACE      8'h20
`define HDLW_CHAR_STD_LAST   8'h7E
`define HDLW_CHAR_UNDEF      8'h7F
`define HDLW_CHAR_EXT_FIRST  8'hA0
`define HDLW_CHAR_NBSP       8'hA0
`define HDLW_CHAR_SOFT_HYPH  8'hAD
`define HDLW_BYTE_RESET      8'h00

`endif

/* File: hw/hdlw_char_filter.v */
// Character code classifier: maps unrenderable codes to a space
`timescale 1ns/1ns
`include "hdlw_consts.vh"

module hdlw_char_filter (
  input  wire [7:0] i_code,    // Raw character byte
  output reg  [7:0] o_glyph    // Code passed to the glyph store
);

  // Standard 0x20..0x7E and extended 0xA0..0xFF pass; the rest shows as space
  always @* begin
    if (i_code >= `HDLW_CHAR_SPACE && i_code <= `HDLW_CHAR_STD_LAST) begin
      o_glyph = i_code;
    end else if (i_code >= `HDLW_CHAR_EXT_FIRST) begin
      o_glyph = i_code;
    end else begin
      o_glyph = `HDLW_CHAR_SPACE;
    end
  end

endmodule

/* File: hw/hdlw_line_writer.v */
// Display line writer fed by the cyclic output image
`timescale 1ns/1ns
`include "hdlw_consts.vh"
//
// Function
// - four lines of sixteen characters, written linewise
// - byte 4 rightmost, byte 19 leftmost
// - decimal point is its own character
// - byte 1 bits 1:0 select line
// - byte 1 bit 7 requests line write
// - input byte 5 bit 7 acknowledges acceptance
// - codes 20..7E standard, 7F undefined
// - codes A0..FF extended Latin set
// - no presence or connection report

module hdlw_line_writer #(
  parameter NUM_LINES = 4,   // Display lines
  parameter NUM_CHARS = 16   // Characters per line
) (
  input  wire                     I_CORE_CLK,   // Core clock, 10 MHz
  input  wire                     I_NRST,       // Synchronous reset, active low
  input  wire                     I_OUT_WE,     // Output image byte write strobe
  input  wire [4:0]               I_OUT_ADDR,   // Output image byte offset
  input  wire [7:0]               I_OUT_DATA,   // Output image byte value
  input  wire [4:0]               I_IN_ADDR,    // Input image byte offset to read
  output reg  [7:0]               O_IN_DATA,    // Input image byte value
  input  wire [1:0]               I_RD_LINE,    // Display refresh line index
  input  wire [3:0]               I_RD_POS,     // Display refresh position, 0 = right
  output reg  [7:0]               O_RD_GLYPH,   // Glyph code at that position
  output reg                      O_MODE_OK,    // Display output mode enabled
  output reg                      O_LINE_STB    // One-cycle pulse on line accept
);

  localparam ST_IDLE   = 1'h0;
  localparam ST_ACK    = 1'h1;
  localparam NUM_CELLS = NUM_LINES * NUM_CHARS;

  // Output byte 1 kept as its two live fields only
  reg  [1:0]                sel_q;
  reg                       req_q;
  reg                       mode_q;
  reg  [7:0]                stage_q [0:NUM_CHARS-1];
  reg  [7:0]                disp_q  [0:NUM_CELLS-1];
  reg                       req_prev_q;
  reg                       state_q;
  reg                       state_d;
  reg                       ack_q;
  reg                       ack_d;
  reg                       commit;
  reg  [7:0]                in_byte_d;
  wire                      wr_ctrl;
  wire                      wr_mode;
  wire                      req_rise;
  wire                      rd_ack;
  wire [NUM_CHARS-1:0]      wr_char;
  wire [7:0]                glyph   [0:NUM_CHARS-1];
  wire [5:0]                rd_idx;

  assign wr_ctrl  = I_OUT_WE && (I_OUT_ADDR == `HDLW_OFS_CTRL);
  assign wr_mode  = I_OUT_WE && (I_OUT_ADDR == `HDLW_OFS_MODE);
  assign req_rise = req_q && !req_prev_q;
  assign rd_ack   = (I_IN_ADDR == `HDLW_IN_OFS_ACK);
  assign rd_idx   = {I_RD_LINE, I_RD_POS};

  // Line select and write request
  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      sel_q <= 2'h0;
      req_q <= 1'h0;
    end else if (wr_ctrl) begin
      sel_q <= I_OUT_DATA[`HDLW_SEL_MSB:`HDLW_SEL_LSB];
      req_q <= I_OUT_DATA[`HDLW_BIT_REQ];
    end
  end

  // Mode bit is only reported; it does not gate line writes
  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      mode_q <= 1'h0;
    end else if (wr_mode) begin
      mode_q <= I_OUT_DATA[`HDLW_BIT_MODE];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CHARS; g = g + 1) begin : g_char
      localparam integer CHAR_OFS = `HDLW_OFS_CHAR_FIRST + g;
      assign wr_char[g] = I_OUT_WE && (I_OUT_ADDR == CHAR_OFS[4:0]);
      // Staging byte g is position g counted from the right
      always @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
          stage_q[g] <= `HDLW_CHAR_SPACE;
        end else if (wr_char[g]) begin
          stage_q[g] <= I_OUT_DATA;
        end
      end
      hdlw_char_filter u_filt (
        .i_code  (stage_q[g]),
        .o_glyph (glyph[g])
      );
    end
  endgenerate

  genvar c;
  generate
    for (c = 0; c < NUM_CELLS; c = c + 1) begin : g_cell
      localparam integer CELL_LINE = c / NUM_CHARS;
      localparam integer CELL_POS  = c % NUM_CHARS;
      // Only the selected line changes; others keep their text
      always @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
          disp_q[c] <= `HDLW_CHAR_SPACE;
        end else if (commit && (sel_q == CELL_LINE[1:0])) begin
          disp_q[c] <= glyph[CELL_POS];
        end
      end
    end
  endgenerate

  // Handshake; a request still high after ack is never taken twice
  always @* begin
    state_d = state_q;
    ack_d   = ack_q;
    commit  = 1'h0;
    case (state_q)
      ST_IDLE: begin
        if (req_rise) begin
          commit  = 1'h1;
          ack_d   = 1'h1;
          state_d = ST_ACK;
        end
      end
      ST_ACK: begin
        if (!req_q) begin
          ack_d   = 1'h0;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        ack_d   = 1'h0;
      end
    endcase
  end

  // No presence bit exists anywhere in the input image
  always @* begin
    in_byte_d = `HDLW_BYTE_RESET;
    if (rd_ack) begin
      in_byte_d[`HDLW_BIT_ACK] = ack_d;
    end
  end

  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      state_q <= ST_IDLE;
      ack_q   <= 1'h0;
    end else begin
      state_q <= state_d;
      ack_q   <= ack_d;
    end
  end

  // Previous request level for the rising-edge test
  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      req_prev_q <= 1'h0;
    end else begin
      req_prev_q <= req_q;
    end
  end

  // One pulse per accepted line
  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      O_LINE_STB <= 1'h0;
    end else begin
      O_LINE_STB <= commit;
    end
  end

  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      O_MODE_OK <= 1'h0;
    end else begin
      O_MODE_OK <= mode_q;
    end
  end

  // Refresh read costs a cycle but keeps the output registered
  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      O_RD_GLYPH <= `HDLW_CHAR_SPACE;
    end else begin
      O_RD_GLYPH <= disp_q[rd_idx];
    end
  end

  // Ack appears in the same cycle as the line strobe
  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      O_IN_DATA <= `HDLW_BYTE_RESET;
    end else begin
      O_IN_DATA <= in_byte_d;
    end
  end

endmodule

/* File: sim/hdlw_line_writer_assertions.sv */
// Port checker for the display line writer
`timescale 1ns/1ns
module hdlw_chk(input wire I_CORE_CLK,I_NRST,I_OUT_WE,O_MODE_OK,O_LINE_STB,
  input wire [4:0] I_OUT_ADDR,I_IN_ADDR,input wire [7:0] I_OUT_DATA,O_IN_DATA,O_RD_GLYPH);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);
  reg  req_q;
  wire rq_w=I_OUT_WE&&I_OUT_ADDR==5'h01;
  wire up_w=rq_w&&I_OUT_DATA[7]&&!req_q;
  wire rd_w=I_IN_ADDR==5'h05;
  always @(posedge I_CORE_CLK) req_q<=I_NRST&&(rq_w?I_OUT_DATA[7]:req_q);
  property p_take;up_w|->##2 O_LINE_STB;endproperty
  a_take:assert property(p_take)else $error("no commit");
  property p_why;O_LINE_STB|->$past(up_w,2);endproperty
  a_why:assert property(p_why)else $error("stray commit");
  property p_one;O_LINE_STB|=>!O_LINE_STB;endproperty
  a_one:assert property(p_one)else $error("long commit");
  property p_rest;!$past(rd_w)|->O_IN_DATA==8'h00;endproperty
  a_rest:assert property(p_rest)else $error("input byte set");
  property p_low;O_IN_DATA[6:0]==7'h00;endproperty
  a_low:assert property(p_low)else $error("ack byte bits");
  property p_ackl;!req_q&&!$past(req_q)&&!$past(req_q,2)&&$past(rd_w)|->!O_IN_DATA[7];endproperty
  a_ackl:assert property(p_ackl)else $error("ack stuck");
  property p_ackh;req_q&&$past(req_q)&&$past(req_q,2)&&$past(rd_w)|->O_IN_DATA[7];endproperty
  a_ackh:assert property(p_ackh)else $error("ack missing");
  property p_code;O_RD_GLYPH inside {[8'h20:8'h7E],[8'hA0:8'hFF]};endproperty
  a_code:assert property(p_code)else $error("bad glyph");
  c_stb:cover property(O_LINE_STB);
  c_ack:cover property(O_IN_DATA[7]);
  c_mode:cover property(O_MODE_OK);
endmodule
bind hdlw_line_writer hdlw_chk chk(.*);

/* File: sim/hdlw_ctl_model.sv */
// Controller model writing display lines via the output image
`timescale 1ns/1ns
module hdlw_ctl(input wire clk,input wire [7:0] ack_b,output reg we,
  output reg [4:0] a,ia,output reg [7:0] d);
  reg got;
  initial begin we=0;a=0;ia=0;d=0;got=0;end
  // Released data is inverted so stale bytes never look valid
  task wr(input [4:0] x,input [7:0] v);begin
    @(posedge clk);#1 we=1;a=x;d=v;@(posedge clk);#1 we=0;d=~v;end
  endtask
  // w delays the clear so slow controllers are covered
  task line(input [1:0] s,input [7:0] b,input integer w);integer k;begin
    wr(5'h01,{6'h00,s});
    for(k=0;k<16;k++)wr(5'h04+k[4:0],b+k[7:0]);
    wr(5'h01,{6'h20,s});ia=5'h05;
    for(k=0;k<50&&!ack_b[7];k++)begin @(posedge clk);#1;end
    got=ack_b[7];
    repeat(w)@(posedge clk);wr(5'h01,{6'h00,s});end
  endtask
endmodule

/* File: sim/test_hdlw_line_writer.sv */
// Self-checking bench for the display line writer
`timescale 1ns/1ns
module test_hdlw_line_writer;
  reg clk=0,nrst=0;reg [1:0] rl=0;reg [3:0] rp=0;
  wire we,md,stb;wire [4:0] a,ia;wire [7:0] d,q,g;
  integer mismatches=0,cmp_count=0,cyc=0,i,p,nstb=0;
  reg [17:0] rows[0:4];
  hdlw_line_writer uut(.I_CORE_CLK(clk),.I_NRST(nrst),.I_OUT_WE(we),.I_OUT_ADDR(a),
    .I_OUT_DATA(d),.I_IN_ADDR(ia),.O_IN_DATA(q),.I_RD_LINE(rl),.I_RD_POS(rp),
    .O_RD_GLYPH(g),.O_MODE_OK(md),.O_LINE_STB(stb));
  hdlw_ctl u(.clk(clk),.ack_b(q),.we(we),.a(a),.ia(ia),.d(d));
  always #50 clk=~clk;
  always @(posedge clk) if(stb) nstb<=nstb+1;
  always @(posedge clk)begin cyc<=cyc+1;if(cyc==20000)begin mismatches++;end_sim;end end
  function [7:0] m(input [7:0] c);m=(c>=8'h20&&c<=8'h7E||c>=8'hA0)?c:8'h20;endfunction
  task ck(input string n,input [7:0] s,e);begin cmp_count++;
    if(s!==e)begin mismatches++;$display("[FAIL] %s exp %h got %h",n,e,s);end end
  endtask
  task rg(input [1:0] l,input [3:0] x,input [7:0] e);begin
    @(posedge clk);#1 rl=l;rp=x;@(posedge clk);#1 ck("glyph",g,e);end
  endtask
  task end_sim;begin
    $display("checks %0d mismatches %0d",cmp_count,mismatches);
    if(mismatches==0&&cmp_count>0)$display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;end
  endtask
  initial begin
    // Rows: line, first byte, expected leftmost glyph
    rows='{18'h04150,18'h17020,18'h298A7,18'h32E3D,18'h0F0FF};
    repeat(8)@(posedge clk);#1 ck("ack",q,8'h00);ck("mode",{7'h00,md},8'h00);nrst=1;
    rg(2'h3,4'h9,8'h20);
    u.wr(5'h00,8'h80);repeat(3)@(posedge clk);#1 ck("mode",{7'h00,md},8'h01);
    for(i=0;i<5;i++)begin
      u.line(rows[i][17:16],rows[i][15:8],i);
      ck("ack seen",{7'h00,u.got},8'h01);
      @(posedge clk);#1 ck("ack clear",q,8'h00);
      for(p=0;p<16;p++)rg(rows[i][17:16],p[3:0],p==15?rows[i][7:0]:m(rows[i][15:8]+p[7:0]));
    end
    // Second set while high must not recommit the changed byte
    u.wr(5'h01,8'h81);u.wr(5'h04,8'h5A);u.wr(5'h01,8'h81);u.wr(5'h01,8'h01);
    rg(2'h1,4'h0,8'hF0);
    rg(2'h3,4'h0,8'h2E);
    ck("strobes",nstb[7:0],8'h06);
    // Mid-run reset clears text, mode and ack
    nrst=0;repeat(2)@(posedge clk);#1 nrst=1;
    ck("mode",{7'h00,md},8'h00);
    rg(2'h1,4'h0,8'h20);
    ck("ack",q,8'h00);
    end_sim;
  end
endmodule
